// ==== common/eig_pkg.sv ====
package eig_pkg;

    // register bus geometry
    localparam int          EIG_ADR_W      = 16;
    localparam int          EIG_DAT_W      = 32;
    localparam int          EIG_CFG_W      = 8;
    localparam int          EIG_CNT_W      = 16;

    // register indices; byte address is four times the index
    localparam logic [15:0] EIG_CFG_IDX    = 16'h0885;
    localparam logic [15:0] EIG_STAT_IDX   = 16'h0886;
    localparam logic [15:0] EIG_CNT_IDX    = 16'h0887;

    // index_track_config fields
    localparam int          EIG_GATE_LSB   = 0;
    localparam int          EIG_GATE_W     = 2;
    localparam int          EIG_SE_BIT     = 3;
    localparam int          EIG_LN_BIT     = 6;
    localparam logic [7:0]  EIG_CFG_MASK   = 8'h4B;
    localparam logic [7:0]  EIG_CFG_RESET  = 8'h40;

    // status register fields
    localparam int          EIG_ST_CMP     = 0;
    localparam int          EIG_ST_QA      = 1;
    localparam int          EIG_ST_QB      = 2;
    localparam int          EIG_ST_ARMED   = 3;
    localparam int          EIG_ST_PULSE   = 4;
    localparam int          EIG_ST_SE      = 5;
    localparam int          EIG_ST_W       = 6;

    // sync stages input vector: {b, a, cmp}
    localparam int          EIG_SYN_W      = 3;

    typedef enum logic [1:0] {
        EIG_GATE_NONE,
        EIG_GATE_A,
        EIG_GATE_B,
        EIG_GATE_AB
    } eig_gate_e;

    typedef enum logic [1:0] {
        EIG_GS_IDLE,
        EIG_GS_ARMED,
        EIG_GS_PULSE
    } eig_gstate_e;

    function automatic logic [EIG_ADR_W-1:0] eig_byte_adr(input logic [15:0] idx);
        eig_byte_adr = {idx[EIG_ADR_W-3:0], 2'b00};
    endfunction

endpackage

// ==== common/eig_gate_if.sv ====
`timescale 1ns/1ps
interface eig_gate_if;
    import eig_pkg::*;

    logic      cmp;
    logic      qa;
    logic      qb;
    eig_gate_e gate_sel;
    logic      pulse;
    logic      armed;

    modport ctrl (
        output cmp,
        output qa,
        output qb,
        output gate_sel,
        input  pulse,
        input  armed
    );

    modport gate (
        input  cmp,
        input  qa,
        input  qb,
        input  gate_sel,
        output pulse,
        output armed
    );

endinterface

// ==== hw/eig_gate.sv ====
`timescale 1ns/1ps
module eig_gate
    import eig_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_b,
    eig_gate_if.gate  gif
);

    logic        prev_cmp_r;
    logic        prev_cmp_nxt;
    logic        prev_a_r;
    logic        prev_a_nxt;
    logic        prev_b_r;
    logic        prev_b_nxt;
    eig_gstate_e st_r;
    eig_gstate_e st_nxt;
    logic        pulse_r;
    logic        pulse_nxt;

    logic        rise_cmp;
    logic        fall_a;
    logic        fall_b;
    logic        rise_a;
    logic        rise_b;
    logic        start;
    logic        stop;

    always_comb begin
        prev_cmp_nxt = gif.cmp;
        prev_a_nxt   = gif.qa;
        prev_b_nxt   = gif.qb;
        rise_cmp     = gif.cmp & ~prev_cmp_r;
        fall_a       = prev_a_r & ~gif.qa;
        fall_b       = prev_b_r & ~gif.qb;
        rise_a       = ~prev_a_r & gif.qa;
        rise_b       = ~prev_b_r & gif.qb;
        // polarity fixed: pulse opens on the falling side of the selected channel
        case (gif.gate_sel)
            EIG_GATE_A: begin
                start = fall_a;
                stop  = rise_a;
            end
            EIG_GATE_B: begin
                start = fall_b;
                stop  = rise_b;
            end
            EIG_GATE_AB: begin
                start = (fall_a & ~gif.qb) | (fall_b & ~gif.qa);
                stop  = rise_a | rise_b;
            end
            default: begin
                start = 1'b0;
                stop  = 1'b0;
            end
        endcase

        st_nxt    = st_r;
        pulse_nxt = 1'b0;
        if (gif.gate_sel == EIG_GATE_NONE) begin
            st_nxt    = EIG_GS_IDLE;
            pulse_nxt = gif.cmp;
        end else begin
            case (st_r)
                EIG_GS_IDLE: begin
                    if (rise_cmp) begin
                        st_nxt = start ? EIG_GS_PULSE : EIG_GS_ARMED;
                    end
                end
                EIG_GS_ARMED: begin
                    // window closed before any edge: no pulse this revolution
                    if (!gif.cmp) begin
                        st_nxt = EIG_GS_IDLE;
                    end else if (start) begin
                        st_nxt = EIG_GS_PULSE;
                    end
                end
                EIG_GS_PULSE: begin
                    if (stop) begin
                        st_nxt = EIG_GS_IDLE;
                    end
                end
                default: begin
                    st_nxt = EIG_GS_IDLE;
                end
            endcase
            pulse_nxt = (st_nxt == EIG_GS_PULSE);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prev_cmp_r <= 1'b0;
            prev_a_r   <= 1'b0;
            prev_b_r   <= 1'b0;
            st_r       <= EIG_GS_IDLE;
            pulse_r    <= 1'b0;
        end else begin
            prev_cmp_r <= prev_cmp_nxt;
            prev_a_r   <= prev_a_nxt;
            prev_b_r   <= prev_b_nxt;
            st_r       <= st_nxt;
            pulse_r    <= pulse_nxt;
        end
    end

    assign gif.pulse = pulse_r;
    assign gif.armed = (st_r == EIG_GS_ARMED);

endmodule

// ==== hw/eig_top.sv ====
// Function
// - positive index stays low, one high pulse per revolution
// - negative index is always the complement of the positive index
// - output-mode bit 0: both index pins driven as a complementary pair
// - output-mode bit 1: negative pin released, only positive pin driven
// - gating 00: positive index follows the index comparator directly
// - gating 01: pulse from first A fall after compare true to next A rise
// - gating 10: pulse from first B fall after compare true to next B rise
// - gating 11: A fall with B low or B fall with A low; ends next rise
// - gating assumes compare positive while selected channel difference negative
// - config register at 0885: gating 1:0, mode bit 3, low-noise bit 6
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
module eig_top
    import eig_pkg::*;
#(
    parameter int CNT_W = EIG_CNT_W
)
(
    input  wire logic                 clock,
    input  wire logic                 rst_b,

    input  wire logic [EIG_ADR_W-1:0] wb_adr_i,
    input  wire logic [EIG_DAT_W-1:0] wb_dat_i,
    output logic      [EIG_DAT_W-1:0] wb_dat_o,
    input  wire logic                 wb_we_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_cyc_i,
    output logic                      wb_ack_o,

    input  wire logic                 index_cmp,
    input  wire logic                 quad_a_digital_out,
    input  wire logic                 quad_b_digital_out,

    output logic                      index_out_pos,
    output logic                      index_out_pos_oe,
    output logic                      index_out_neg,
    output logic                      index_out_neg_oe,
    output logic                      low_noise_path_sel
);

    // input synchronisers, {b, a, cmp}
    logic [EIG_SYN_W-1:0] sync1_r;
    logic [EIG_SYN_W-1:0] sync1_nxt;
    logic [EIG_SYN_W-1:0] sync2_r;
    logic [EIG_SYN_W-1:0] sync2_nxt;

    // bus slave
    logic                 ack_r;
    logic                 ack_nxt;
    logic [EIG_DAT_W-1:0] dat_r;
    logic [EIG_DAT_W-1:0] dat_nxt;
    logic                 req;
    logic                 wr_commit;
    logic                 hit_cfg;
    logic                 hit_stat;
    logic                 hit_cnt;

    // software state
    logic [EIG_CFG_W-1:0] cfg_r;
    logic [EIG_CFG_W-1:0] cfg_nxt;
    logic [CNT_W-1:0]     cnt_r;
    logic [CNT_W-1:0]     cnt_nxt;
    logic                 pulse_d_r;
    logic                 pulse_d_nxt;
    logic                 pulse_rise;
    logic [EIG_ST_W-1:0]  status;

    // pin drivers
    logic                 pos_r;
    logic                 pos_nxt;
    logic                 neg_r;
    logic                 neg_nxt;
    logic                 neg_oe_r;
    logic                 neg_oe_nxt;

    eig_gate_if gif ();

    // a write lands only with the low byte lane enabled
    function automatic logic lane0_write(input logic       commit,
                                         input logic       hit,
                                         input logic [3:0] sel);
        lane0_write = commit & hit & sel[0];
    endfunction

    // comparator is analog and quadrature may come from the interpolator's
    // own timing; all three share the same delay so edges stay aligned
    always_comb begin
        sync1_nxt = {quad_b_digital_out, quad_a_digital_out, index_cmp};
        sync2_nxt = sync1_r;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    assign gif.cmp      = sync2_r[0];
    assign gif.qa       = sync2_r[1];
    assign gif.qb       = sync2_r[2];
    assign gif.gate_sel = eig_gate_e'(cfg_r[EIG_GATE_LSB +: EIG_GATE_W]);

    eig_gate i_eig_gate (
        .clock (clock),
        .rst_b (rst_b),
        .gif   (gif.gate)
    );

    // address decode
    always_comb begin
        hit_cfg  = 1'b0;
        hit_stat = 1'b0;
        hit_cnt  = 1'b0;
        if (wb_adr_i == eig_byte_adr(EIG_CFG_IDX)) begin
            hit_cfg = 1'b1;
        end else if (wb_adr_i == eig_byte_adr(EIG_STAT_IDX)) begin
            hit_stat = 1'b1;
        end else if (wb_adr_i == eig_byte_adr(EIG_CNT_IDX)) begin
            hit_cnt = 1'b1;
        end
    end

    always_comb begin
        status               = '0;
        status[EIG_ST_CMP]   = gif.cmp;
        status[EIG_ST_QA]    = gif.qa;
        status[EIG_ST_QB]    = gif.qb;
        status[EIG_ST_ARMED] = gif.armed;
        status[EIG_ST_PULSE] = gif.pulse;
        status[EIG_ST_SE]    = ~cfg_r[EIG_SE_BIT];
    end

    // request taken one cycle, acked the next; write lands on the ack edge
    // so address and data are still held by the master when it commits
    always_comb begin
        req       = wb_cyc_i & wb_stb_i & ~ack_r;
        wr_commit = wb_cyc_i & wb_stb_i & ack_r & wb_we_i;
        ack_nxt   = req;
        dat_nxt   = dat_r;
        if (req) begin
            dat_nxt = '0;
            if (!wb_we_i) begin
                // unmapped and reserved bits read as zero
                if (hit_cfg) begin
                    dat_nxt[EIG_CFG_W-1:0] = cfg_r;
                end else if (hit_stat) begin
                    dat_nxt[EIG_ST_W-1:0] = status;
                end else if (hit_cnt) begin
                    dat_nxt[CNT_W-1:0] = cnt_r;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // configuration and pulse counter
    always_comb begin
        cfg_nxt     = cfg_r;
        cnt_nxt     = cnt_r;
        pulse_d_nxt = gif.pulse;
        pulse_rise  = gif.pulse & ~pulse_d_r;
        if (lane0_write(wr_commit, hit_cfg, wb_sel_i)) begin
            // low-noise bit stored as written; software keeps it at 1
            cfg_nxt = wb_dat_i[EIG_CFG_W-1:0] & EIG_CFG_MASK;
        end
        if (lane0_write(wr_commit, hit_cnt, wb_sel_i)) begin
            cnt_nxt = '0;
        end
        // a pulse in the clearing cycle still counts
        if (pulse_rise) begin
            cnt_nxt = cnt_nxt + CNT_W'(1);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg_r     <= EIG_CFG_RESET;
            cnt_r     <= '0;
            pulse_d_r <= 1'b0;
        end else begin
            cfg_r     <= cfg_nxt;
            cnt_r     <= cnt_nxt;
            pulse_d_r <= pulse_d_nxt;
        end
    end

    // pin drivers; registered so both pins switch on the same edge
    always_comb begin
        pos_nxt    = gif.pulse;
        neg_nxt    = ~gif.pulse;
        neg_oe_nxt = ~cfg_r[EIG_SE_BIT];
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pos_r    <= 1'b0;
            neg_r    <= 1'b1;
            neg_oe_r <= 1'b1;
        end else begin
            pos_r    <= pos_nxt;
            neg_r    <= neg_nxt;
            neg_oe_r <= neg_oe_nxt;
        end
    end

    assign index_out_pos      = pos_r;
    // positive pin is driven in both output modes
    assign index_out_pos_oe   = 1'b1;
    assign index_out_neg      = neg_r;
    assign index_out_neg_oe   = neg_oe_r;
    assign low_noise_path_sel = cfg_r[EIG_LN_BIT];

endmodule

// ==== testbench/eig_top_properties.sv ====
`timescale 1ns/1ps
module eig_top_properties
    import eig_pkg::*;
#(
    parameter int CNT_W = EIG_CNT_W
)
(
    input wire logic                 clock,
    input wire logic                 rst_b,
    input wire logic [EIG_ADR_W-1:0] wb_adr_i,
    input wire logic [EIG_DAT_W-1:0] wb_dat_i,
    input wire logic [EIG_DAT_W-1:0] wb_dat_o,
    input wire logic                 wb_we_i,
    input wire logic [3:0]           wb_sel_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_ack_o,
    input wire logic                 index_cmp,
    input wire logic                 quad_a_digital_out,
    input wire logic                 quad_b_digital_out,
    input wire logic                 index_out_pos,
    input wire logic                 index_out_pos_oe,
    input wire logic                 index_out_neg,
    input wire logic                 index_out_neg_oe,
    input wire logic                 low_noise_path_sel
);
    logic [7:0] cfg_r;
    logic [3:0] quiet_r;
    logic [3:0] hi_r;
    logic       wr_cfg;
    logic       hi_now;

    assign wr_cfg = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == 16'h2214;
    // gated pulse cannot stand once the selected channels have been high a while
    assign hi_now = (cfg_r[1:0] == 2'b01) ? quad_a_digital_out
        : (cfg_r[1:0] == 2'b10) ? quad_b_digital_out
        : quad_a_digital_out && quad_b_digital_out;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg_r   <= EIG_CFG_RESET;
            quiet_r <= 4'h0;
            hi_r    <= 4'h0;
        end else begin
            cfg_r   <= wr_cfg ? wb_dat_i[7:0] & EIG_CFG_MASK : cfg_r;
            quiet_r <= wr_cfg ? 4'h0 : (quiet_r == 4'hF ? quiet_r : quiet_r + 4'h1);
            hi_r    <= !hi_now ? 4'h0 : (hi_r == 4'hF ? hi_r : hi_r + 4'h1);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_neg_comp; index_out_neg != index_out_pos; endproperty
    property p_pos_oe; index_out_pos_oe; endproperty
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    property p_ack_req; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_cfg_apply;
        wr_cfg |-> ##2 (index_out_neg_oe == !cfg_r[EIG_SE_BIT])
            && (low_noise_path_sel == cfg_r[EIG_LN_BIT]);
    endproperty
    property p_ungated;
        cfg_r[1:0] == 2'b00 && quiet_r > 4'h6 |-> index_out_pos == $past(index_cmp, 4);
    endproperty
    property p_gate_idle;
        cfg_r[1:0] != 2'b00 && quiet_r > 4'h8 && hi_r > 4'h6 |-> !index_out_pos;
    endproperty
    property p_gate_start;
        $rose(index_out_pos) && cfg_r[1:0] == 2'b01 && quiet_r > 4'h8
            |-> !$past(quad_a_digital_out, 3);
    endproperty

    a_neg_comp: assert property (p_neg_comp) else $error("neg not complement");
    a_pos_oe: assert property (p_pos_oe) else $error("pos pin released");
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    a_ack_req: assert property (p_ack_req) else $error("ack missing");
    a_cfg_apply: assert property (p_cfg_apply) else $error("cfg not applied");
    a_ungated: assert property (p_ungated) else $error("ungated mismatch");
    a_gate_idle: assert property (p_gate_idle) else $error("pulse while high");
    a_gate_start: assert property (p_gate_start) else $error("start without fall");

    c_ungated: cover property (cfg_r[1:0] == 2'b00 && $rose(index_out_pos));
    c_gate_ab: cover property (cfg_r[1:0] == 2'b11 && $rose(index_out_pos));
    c_single: cover property (!index_out_neg_oe);
endmodule

bind eig_top eig_top_properties #(.CNT_W(CNT_W)) i_eig_top_properties (.*);

// ==== testbench/eig_ctrl_model.sv ====
`timescale 1ns/1ps
module eig_ctrl_model (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       index_out_pos,
    input  wire logic       index_out_neg,
    input  wire logic       index_out_neg_oe,
    output logic      [7:0] pulse_cnt,
    output logic            pair_err
);
    logic last_pos_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pulse_cnt  <= 8'h00;
            pair_err   <= 1'b0;
            last_pos_r <= 1'b0;
        end else begin
            last_pos_r <= index_out_pos;
            if (index_out_pos && !last_pos_r) begin
                pulse_cnt <= pulse_cnt + 8'h01;
            end
            // a released neg pin is not judged
            if (index_out_neg_oe && index_out_neg === index_out_pos) begin
                pair_err <= 1'b1;
            end
        end
    end
endmodule

// ==== testbench/eig_top_tb.sv ====
`timescale 1ns/1ps
module eig_top_tb;
    import eig_pkg::*;
    logic        clock, rst_b, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
    logic [15:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0]  wb_sel_i;
    logic        index_cmp, quad_a_digital_out, quad_b_digital_out;
    logic        index_out_pos, index_out_pos_oe, index_out_neg, index_out_neg_oe;
    logic        low_noise_path_sel, pair_err;
    logic [7:0]  pulse_cnt;
    int          err_total = 0;
    int          num_checks = 0;

    eig_top i_eig_top (.*);
    eig_ctrl_model i_eig_ctrl_model (.*);

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb_xfer(input logic [15:0] a, input logic w, input logic [31:0] d,
                           input logic [3:0] s, output logic [31:0] r);
        @(posedge clock);
        wb_adr_i <= a;
        wb_we_i  <= w;
        wb_dat_i <= d;
        wb_sel_i <= s;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // six cycles covers the four-edge pin latency
    task automatic pins(input logic c, input logic a, input logic b);
        @(posedge clock);
        index_cmp          <= c;
        quad_a_digital_out <= a;
        quad_b_digital_out <= b;
        repeat (6) @(posedge clock);
    endtask

    task automatic t_regs();
        logic [31:0] r;
        wb_xfer(16'h2214, 1'b0, 32'h0, 4'hF, r);
        check(r, {24'h0, EIG_CFG_RESET});
        check({index_out_pos, index_out_neg, index_out_neg_oe}, 3'b011);
        wb_xfer(16'h2214, 1'b1, 32'hFF, 4'hF, r);
        wb_xfer(16'h2214, 1'b0, 32'h0, 4'hF, r);
        check(r, 32'h4B);
        check({index_out_neg_oe, low_noise_path_sel}, 2'b01);
        wb_xfer(16'h2214, 1'b1, 32'h40, 4'hE, r);
        wb_xfer(16'h0100, 1'b1, 32'hFF, 4'hF, r);
        wb_xfer(16'h0100, 1'b0, 32'h0, 4'hF, r);
        check(r, 32'h0);
        wb_xfer(16'h2214, 1'b0, 32'h0, 4'hF, r);
        check(r, 32'h4B);
        wb_xfer(16'h2214, 1'b1, 32'h40, 4'hF, r);
        repeat (2) @(posedge clock);
        check({index_out_neg_oe, low_noise_path_sel}, 2'b11);
        $display("test regs done");
    endtask

    task automatic t_ungated();
        pins(1'b1, 1'b1, 1'b0);
        check({index_out_pos, index_out_neg}, 2'b10);
        pins(1'b0, 1'b0, 1'b1);
        check({index_out_pos, index_out_neg}, 2'b01);
        $display("test ungated done");
    endtask

    // g selects one channel; the other is dropped first and must not start a pulse
    task automatic t_gated(input logic [1:0] g);
        logic [31:0] r;
        wb_xfer(16'h2214, 1'b1, {24'h0, 6'h10, g}, 4'hF, r);
        pins(1'b0, 1'b1, 1'b1);
        pins(1'b1, 1'b1, 1'b1);
        pins(1'b1, g[0], g[1]);
        check(index_out_pos, 1'b0);
        wb_xfer(16'h2218, 1'b0, 32'h0, 4'hF, r);
        check(r, {26'h0, 3'b101, g[1], g[0], 1'b1});
        pins(1'b1, 1'b1, 1'b1);
        pins(1'b1, g[1], g[0]);
        check({index_out_pos, index_out_neg}, 2'b10);
        pins(1'b1, 1'b1, 1'b1);
        check(index_out_pos, 1'b0);
        pins(1'b1, g[1], g[0]);
        check(index_out_pos, 1'b0);
        pins(1'b0, 1'b1, 1'b1);
        $display("test gated %0d done", g);
    endtask

    task automatic t_gate_ab();
        logic [31:0] r;
        wb_xfer(16'h2214, 1'b1, 32'h43, 4'hF, r);
        pins(1'b1, 1'b1, 1'b1);
        pins(1'b1, 1'b1, 1'b0);
        check(index_out_pos, 1'b0);
        pins(1'b1, 1'b0, 1'b0);
        check({index_out_pos, index_out_neg}, 2'b10);
        wb_xfer(16'h2218, 1'b0, 32'h0, 4'hF, r);
        check(r, 32'h31);
        pins(1'b1, 1'b0, 1'b1);
        check(index_out_pos, 1'b0);
        pins(1'b0, 1'b1, 1'b1);
        wb_xfer(16'h221C, 1'b0, 32'h0, 4'hF, r);
        check(r, 32'h4);
        wb_xfer(16'h221C, 1'b1, 32'h0, 4'h1, r);
        wb_xfer(16'h221C, 1'b0, 32'h0, 4'hF, r);
        check(r, 32'h0);
        check({pulse_cnt, pair_err}, {8'h04, 1'b0});
        $display("test gated ab done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        tally_and_finish();
    end

    initial begin
        rst_b = 1'b0;
        {wb_we_i, wb_stb_i, wb_cyc_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
        {index_cmp, quad_a_digital_out, quad_b_digital_out} = 3'b011;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        t_regs();
        t_ungated();
        t_gated(2'b01);
        t_gated(2'b10);
        t_gate_ab();
        tally_and_finish();
    end
endmodule
